// *** t8co_pkg.sv ***
// Constants, register map and state type of the 8-bit timer compare block
// Contract
// - In non-PWM modes a force strobe write acts like a compare match.
// - Forced compare sets no flag, leaves counter alone, updates output per mode.
// - Counter write suppresses any compare match in the next timer tick.
// - Compare output keeps its value across waveform mode changes.
// - Output mode bits are unbuffered; new setting rules next match or force.
// - Nonzero output mode makes compare output replace port value on pin.
// - Pin direction stays with direction bit; compare output visible only as output.
// - Output mode zero leaves compare output unchanged at matches.
// - Counting depends only on waveform mode, never on output mode bits.
// - Waveform mode zero always increments, wrapping 0xFF to 0x00.
// - Normal mode sets overflow flag as counter becomes zero; only set.
// - Normal mode accepts counter writes at any time.
// - Waveform mode 2 clears counter after it equals compare value.
// - Clear-on-match compare writes are unbuffered; low value wraps via 0xFF first.
// - Clear-on-match mode raises compare flag each time counter reaches top.
// - Clear-on-match output mode 1 inverts compare output on every match.
// - Toggle frequency is clock over two times prescale times one plus compare.
// - Clear-on-match mode sets overflow flag on pass from maximum to 0x00.
// - Compare equality sets compare flag one timer clock later.
// - Counter maximum is 0xFF; zero is bottom.
// - Counter write wins over simultaneous clear or count.
// - Clock select zero stops counting; counter stays readable and writable.

package t8co_pkg;

   // ************************************************************
   // Register map (byte addresses)
   // ************************************************************
   localparam logic [4:0] ADDR_CONTROL = 5'h00;
   localparam logic [4:0] ADDR_COUNTER = 5'h04;
   localparam logic [4:0] ADDR_COMPARE = 5'h08;
   localparam logic [4:0] ADDR_FLAGS   = 5'h0C;
   localparam logic [4:0] ADDR_PORT    = 5'h10;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int CTRL_WGM_LSB   = 0;
   localparam int CTRL_COM_LSB   = 4;
   localparam int CTRL_FORCE_BIT = 7;
   localparam int CTRL_CS_LSB    = 8;
   localparam int FLAG_OVF_BIT   = 0;
   localparam int FLAG_OCF_BIT   = 1;
   localparam int PORT_VAL_BIT   = 0;
   localparam int PORT_DIR_BIT   = 1;

   // ************************************************************
   // Encodings and values
   // ************************************************************
   localparam logic [1:0] WGM_NORMAL = 2'h0;
   localparam logic [1:0] WGM_PHASE  = 2'h1;
   localparam logic [1:0] WGM_CTC    = 2'h2;
   localparam logic [1:0] WGM_FAST   = 2'h3;
   localparam logic [1:0] COM_NONE   = 2'h0;
   localparam logic [1:0] COM_TOGGLE = 2'h1;
   localparam logic [1:0] COM_CLEAR  = 2'h2;
   localparam logic [1:0] COM_SET    = 2'h3;
   localparam logic [2:0] CS_STOP    = 3'h0;
   localparam logic [2:0] CS_DIV1    = 3'h1;
   localparam logic [7:0] CNT_MAX    = 8'hFF;
   localparam logic [7:0] CNT_BOTTOM = 8'h00;

   // Prescaler terminal counts (divide minus one)
   localparam logic [9:0] PRE_LAST_8    = 10'h007;
   localparam logic [9:0] PRE_LAST_32   = 10'h01F;
   localparam logic [9:0] PRE_LAST_64   = 10'h03F;
   localparam logic [9:0] PRE_LAST_128  = 10'h07F;
   localparam logic [9:0] PRE_LAST_256  = 10'h0FF;
   localparam logic [9:0] PRE_LAST_1024 = 10'h3FF;

   // ************************************************************
   // Block state
   // ************************************************************
   typedef struct packed {
      logic [1:0]  waveform_mode;
      logic [1:0]  compare_output_mode;
      logic [2:0]  clock_select;
      logic [7:0]  counter_value;
      logic [7:0]  compare_value;
      logic        overflow_flag;
      logic        compare_match_flag;
      logic        compare_output;
      logic        match_block;
      logic        port_value;
      logic        compare_pin_direction;
      logic [9:0]  prescale;
      logic        waitreq;
      logic [31:0] rdata;
      logic        pin_out;
      logic        pin_oe;
   } t8co_state_t;

endpackage : t8co_pkg

// *** t8co_top.sv ***
// Timer compare unit with normal and clear-on-match modes behind an Avalon-MM slave
`timescale 1ns/10ps
`default_nettype none

module t8co_top (
   input  wire logic        REF_CLK,
   input  wire logic        SYS_RST,
   input  wire logic [4:0]  AVS_ADDRESS,
   input  wire logic        AVS_READ,
   input  wire logic        AVS_WRITE,
   input  wire logic [31:0] AVS_WRITEDATA,
   input  wire logic [3:0]  AVS_BYTEENABLE,
   output logic [31:0]      AVS_READDATA,
   output logic             AVS_WAITREQUEST,
   output logic             COMPARE_PIN_OUT,
   output logic             COMPARE_PIN_OE,
   output logic             OVERFLOW_FLAG,
   output logic             COMPARE_MATCH_FLAG
);

   // ************************************************************
   // State
   // ************************************************************
   t8co_pkg::t8co_state_t st_q;
   t8co_pkg::t8co_state_t st_d;

   // ************************************************************
   // Prescaler terminal count
   // ************************************************************
   function automatic logic [9:0] pre_last(input logic [2:0] cs);
      logic [9:0] r;
      r = 10'h000;
      unique case (cs)
         3'h2:    r = t8co_pkg::PRE_LAST_8;
         3'h3:    r = t8co_pkg::PRE_LAST_32;
         3'h4:    r = t8co_pkg::PRE_LAST_64;
         3'h5:    r = t8co_pkg::PRE_LAST_128;
         3'h6:    r = t8co_pkg::PRE_LAST_256;
         3'h7:    r = t8co_pkg::PRE_LAST_1024;
         default: r = 10'h000;
      endcase
      return r;
   endfunction : pre_last

   // ************************************************************
   // Compare output action
   // ************************************************************
   function automatic logic oc_action(input logic [1:0] com, input logic oc);
      logic r;
      r = oc;
      unique case (com)
         t8co_pkg::COM_NONE:   r = oc;
         t8co_pkg::COM_TOGGLE: r = ~oc;
         t8co_pkg::COM_CLEAR:  r = 1'b0;
         t8co_pkg::COM_SET:    r = 1'b1;
      endcase
      return r;
   endfunction : oc_action

   // ************************************************************
   // Next state
   // ************************************************************
   logic        tick;
   logic        match;
   logic        force_cmp;
   logic        wr;
   logic        wr_ctrl;
   logic        wr_cnt;
   logic        wr_cmp;
   logic        wr_flag;
   logic        wr_port;
   logic        non_pwm_now;
   logic        non_pwm_new;
   logic [31:0] rmux;

   always_comb begin
      st_d = st_q;
      wr      = AVS_WRITE && !st_q.waitreq;
      wr_ctrl = wr && (AVS_ADDRESS == t8co_pkg::ADDR_CONTROL);
      wr_cnt  = wr && (AVS_ADDRESS == t8co_pkg::ADDR_COUNTER) && AVS_BYTEENABLE[0];
      wr_cmp  = wr && (AVS_ADDRESS == t8co_pkg::ADDR_COMPARE) && AVS_BYTEENABLE[0];
      wr_flag = wr && (AVS_ADDRESS == t8co_pkg::ADDR_FLAGS) && AVS_BYTEENABLE[0];
      wr_port = wr && (AVS_ADDRESS == t8co_pkg::ADDR_PORT) && AVS_BYTEENABLE[0];

      // Timer clock enable
      tick = (st_q.clock_select == t8co_pkg::CS_DIV1) ||
             ((st_q.clock_select != t8co_pkg::CS_STOP) &&
              (st_q.prescale == pre_last(st_q.clock_select)));
      if (st_q.clock_select == t8co_pkg::CS_STOP) begin
         st_d.prescale = 10'h000;
      end else if (tick) begin
         st_d.prescale = 10'h000;
      end else begin
         st_d.prescale = st_q.prescale + 10'h001;
      end

      non_pwm_now = (st_q.waveform_mode == t8co_pkg::WGM_NORMAL) ||
                    (st_q.waveform_mode == t8co_pkg::WGM_CTC);
      non_pwm_new = (AVS_WRITEDATA[t8co_pkg::CTRL_WGM_LSB +: 2] == t8co_pkg::WGM_NORMAL) ||
                    (AVS_WRITEDATA[t8co_pkg::CTRL_WGM_LSB +: 2] == t8co_pkg::WGM_CTC);

      // Equality seen on a tick, unless a counter write blocks it
      match = tick && (st_q.counter_value == st_q.compare_value) && !st_q.match_block;
      if (tick) begin
         st_d.match_block = 1'b0;
      end

      // Counter: write first, then clear or count
      if (wr_cnt) begin
         st_d.counter_value = AVS_WRITEDATA[7:0];
         st_d.match_block   = 1'b1;
      end else if (tick) begin
         if ((st_q.waveform_mode == t8co_pkg::WGM_CTC) && match) begin
            st_d.counter_value = t8co_pkg::CNT_BOTTOM;
         end else begin
            st_d.counter_value = st_q.counter_value + 8'h01;
         end
      end

      // Flags: write one clears, hardware set wins
      if (wr_flag && AVS_WRITEDATA[t8co_pkg::FLAG_OVF_BIT]) begin
         st_d.overflow_flag = 1'b0;
      end
      if (wr_flag && AVS_WRITEDATA[t8co_pkg::FLAG_OCF_BIT]) begin
         st_d.compare_match_flag = 1'b0;
      end
      if (tick && !wr_cnt && (st_q.counter_value == t8co_pkg::CNT_MAX)) begin
         st_d.overflow_flag = 1'b1;
      end
      if (match) begin
         st_d.compare_match_flag = 1'b1;
      end

      // Compare value, unbuffered in these modes
      if (wr_cmp) begin
         st_d.compare_value = AVS_WRITEDATA[7:0];
      end

      // Control register; mode change leaves compare output alone
      force_cmp = 1'b0;
      if (wr_ctrl && AVS_BYTEENABLE[0]) begin
         st_d.waveform_mode       = AVS_WRITEDATA[t8co_pkg::CTRL_WGM_LSB +: 2];
         st_d.compare_output_mode = AVS_WRITEDATA[t8co_pkg::CTRL_COM_LSB +: 2];
         force_cmp = AVS_WRITEDATA[t8co_pkg::CTRL_FORCE_BIT] && non_pwm_new;
      end
      if (wr_ctrl && AVS_BYTEENABLE[1]) begin
         st_d.clock_select = AVS_WRITEDATA[t8co_pkg::CTRL_CS_LSB +: 3];
      end

      // Output action from a match or a force, with the newest mode bits
      if (force_cmp || (match && non_pwm_now)) begin
         st_d.compare_output = oc_action(st_d.compare_output_mode, st_q.compare_output);
      end

      if (wr_port) begin
         st_d.port_value            = AVS_WRITEDATA[t8co_pkg::PORT_VAL_BIT];
         st_d.compare_pin_direction = AVS_WRITEDATA[t8co_pkg::PORT_DIR_BIT];
      end

      // Pin override and direction
      st_d.pin_out = (st_d.compare_output_mode != t8co_pkg::COM_NONE) ?
                     st_d.compare_output : st_d.port_value;
      st_d.pin_oe  = st_d.compare_pin_direction;

      // Bus read mux
      rmux = 32'h0000_0000;
      unique case (AVS_ADDRESS)
         t8co_pkg::ADDR_CONTROL: begin
            rmux[t8co_pkg::CTRL_WGM_LSB +: 2] = st_q.waveform_mode;
            rmux[t8co_pkg::CTRL_COM_LSB +: 2] = st_q.compare_output_mode;
            rmux[t8co_pkg::CTRL_CS_LSB +: 3]  = st_q.clock_select;
         end
         t8co_pkg::ADDR_COUNTER: rmux[7:0] = st_q.counter_value;
         t8co_pkg::ADDR_COMPARE: rmux[7:0] = st_q.compare_value;
         t8co_pkg::ADDR_FLAGS: begin
            rmux[t8co_pkg::FLAG_OVF_BIT] = st_q.overflow_flag;
            rmux[t8co_pkg::FLAG_OCF_BIT] = st_q.compare_match_flag;
         end
         t8co_pkg::ADDR_PORT: begin
            rmux[t8co_pkg::PORT_VAL_BIT] = st_q.port_value;
            rmux[t8co_pkg::PORT_DIR_BIT] = st_q.compare_pin_direction;
         end
         default: rmux = 32'h0000_0000;
      endcase

      // One wait cycle per request
      if ((AVS_READ || AVS_WRITE) && st_q.waitreq) begin
         st_d.waitreq = 1'b0;
         st_d.rdata   = AVS_READ ? rmux : 32'h0000_0000;
      end else begin
         st_d.waitreq = 1'b1;
      end
   end

   // ************************************************************
   // Registers
   // ************************************************************
   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         st_q         <= '0;
         st_q.waitreq <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign AVS_READDATA       = st_q.rdata;
   assign AVS_WAITREQUEST    = st_q.waitreq;
   assign COMPARE_PIN_OUT    = st_q.pin_out;
   assign COMPARE_PIN_OE     = st_q.pin_oe;
   assign OVERFLOW_FLAG      = st_q.overflow_flag;
   assign COMPARE_MATCH_FLAG = st_q.compare_match_flag;

endmodule : t8co_top

`default_nettype wire

// *** t8co_monitor.sv ***
// Port checker for the timer compare block
`timescale 1ns/10ps
`default_nettype none
module t8co_monitor (
   input wire logic        REF_CLK,
   input wire logic        SYS_RST,
   input wire logic [4:0]  AVS_ADDRESS,
   input wire logic        AVS_READ,
   input wire logic        AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0]  AVS_BYTEENABLE,
   input wire logic [31:0] AVS_READDATA,
   input wire logic        AVS_WAITREQUEST,
   input wire logic        COMPARE_PIN_OUT,
   input wire logic        COMPARE_PIN_OE,
   input wire logic        OVERFLOW_FLAG,
   input wire logic        COMPARE_MATCH_FLAG
);
   logic       wr_ctl;
   logic       wr_frc;
   logic       wr_port;
   logic       wr_flag;
   logic [5:0] shd_q;
   logic [5:0] shd_d;
   assign wr_ctl  = AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == t8co_pkg::ADDR_CONTROL;
   assign wr_frc  = wr_ctl && AVS_BYTEENABLE[0] && AVS_WRITEDATA[7];
   assign wr_port = AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == t8co_pkg::ADDR_PORT && AVS_BYTEENABLE[0];
   assign wr_flag = AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == t8co_pkg::ADDR_FLAGS && AVS_BYTEENABLE[0];
   // Shadow of output mode, clock select and port value
   assign shd_d[5:4] = (wr_ctl && AVS_BYTEENABLE[0]) ? AVS_WRITEDATA[5:4] : shd_q[5:4];
   assign shd_d[3:1] = (wr_ctl && AVS_BYTEENABLE[1]) ? AVS_WRITEDATA[10:8] : shd_q[3:1];
   assign shd_d[0]   = wr_port ? AVS_WRITEDATA[0] : shd_q[0];
   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         shd_q <= 6'h00;
      end else begin
         shd_q <= shd_d;
      end
   end
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (SYS_RST);
   sequence s_answer;
      !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
   endsequence
   a_wait_one_cycle: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> s_answer)
      else $error("bus answer is not one low cycle of waitrequest");
   a_pin_dir_follow: assert property (wr_port |=> COMPARE_PIN_OE == $past(AVS_WRITEDATA[1]))
      else $error("pin enable does not follow the direction bit");
   a_port_passthru: assert property (shd_q[5:4] == 2'h0 |-> COMPARE_PIN_OUT == shd_q[0])
      else $error("pin does not show the port value");
   a_force_reads_zero: assert property (AVS_READ && !AVS_WAITREQUEST &&
      AVS_ADDRESS == t8co_pkg::ADDR_CONTROL |-> !AVS_READDATA[7])
      else $error("force strobe reads back as one");
   a_stop_no_flag: assert property ($rose(OVERFLOW_FLAG) || $rose(COMPARE_MATCH_FLAG)
      |-> ($past(shd_q) & 6'h0E) != 6'h00)
      else $error("flag raised while the clock was stopped");
   a_output_held: assert property (!$stable(COMPARE_PIN_OUT) && ($past(shd_q) & 6'h0E) == 6'h00 &&
      ($past(shd_q) & 6'h30) != 6'h00 && shd_q[5:4] != 2'h0 |-> $past(wr_frc))
      else $error("compare output changed without a force while stopped");
   a_ovf_set_only: assert property ($fell(OVERFLOW_FLAG) |-> $past(wr_flag) && $past(AVS_WRITEDATA[0]))
      else $error("overflow flag cleared without a software clear");
   a_ocf_set_only: assert property ($fell(COMPARE_MATCH_FLAG) |-> $past(wr_flag) && $past(AVS_WRITEDATA[1]))
      else $error("compare flag cleared without a software clear");
endmodule : t8co_monitor

bind t8co_top t8co_monitor t8co_monitor_i (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .AVS_ADDRESS(AVS_ADDRESS),
   .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
   .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .COMPARE_PIN_OUT(COMPARE_PIN_OUT),
   .COMPARE_PIN_OE(COMPARE_PIN_OE), .OVERFLOW_FLAG(OVERFLOW_FLAG), .COMPARE_MATCH_FLAG(COMPARE_MATCH_FLAG));
`default_nettype wire

// *** t8co_tb_top.sv ***
// Self-checking bench for the timer compare block
`timescale 1ns/10ps
`default_nettype none
module t8co_tb_top;
   localparam int         DIVS [7] = '{1, 8, 32, 64, 128, 256, 1024};
   localparam logic [1:0] COMS [4] = '{2'h2, 2'h3, 2'h1, 2'h1};
   logic        clk;
   logic        rst;
   logic [4:0]  adr;
   logic        rd_en;
   logic        wr_en;
   logic [31:0] wdat;
   logic [31:0] rdat;
   logic        wait_r;
   logic        pin;
   logic        oe;
   logic        ovf;
   logic        ocf;
   logic [31:0] rd;
   int          mismatches;
   int          check_count;
   int          n;
   t8co_top t8co_top_i (.REF_CLK(clk), .SYS_RST(rst), .AVS_ADDRESS(adr), .AVS_READ(rd_en), .AVS_WRITE(wr_en),
      .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(4'h3), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wait_r),
      .COMPARE_PIN_OUT(pin), .COMPARE_PIN_OE(oe), .OVERFLOW_FLAG(ovf), .COMPARE_MATCH_FLAG(ocf));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      @(posedge clk);
      adr <= a;
      wr_en <= wr;
      rd_en <= !wr;
      wdat <= d;
      do begin
         @(posedge clk);
      end while (wait_r !== 1'b0);
      rd = rdat;
      rd_en <= 1'b0;
      wr_en <= 1'b0;
   endtask : bus
   task automatic rdchk(input logic [4:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      check(rd, exp);
   endtask : rdchk
   // Edges until overflow, compare flag or a pin change is seen
   task automatic wait_ev(input int sel);
      logic p;
      p = pin;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (!((sel == 0 && ovf === 1'b1) || (sel == 1 && ocf === 1'b1) || (sel == 2 && pin !== p)));
   endtask : wait_ev
   function automatic logic [31:0] ctl(input logic [1:0] wgm, input logic [1:0] com, input logic f,
                                       input logic [2:0] cs);
      return {21'h0, cs, f, 1'b0, com, 2'h0, wgm};
   endfunction : ctl
   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : end_of_test
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      repeat (60000) @(posedge clk);
      mismatches++;
      end_of_test();
   end
   initial begin
      rst = 1'b1;
      adr = 5'h00;
      rd_en = 1'b0;
      wr_en = 1'b0;
      wdat = 32'h0;
      mismatches = 0;
      check_count = 0;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      for (int a = 0; a <= 20; a += 4) begin
         rdchk(5'(a), 32'h0);
      end
      bus(1'b1, t8co_pkg::ADDR_COUNTER, 32'hFE);
      bus(1'b1, t8co_pkg::ADDR_COMPARE, 32'h10);
      bus(1'b1, t8co_pkg::ADDR_CONTROL, ctl(2'h0, 2'h0, 1'b0, 3'h1));
      wait_ev(0);
      check(n, 3);
      bus(1'b1, t8co_pkg::ADDR_CONTROL, ctl(2'h0, 2'h0, 1'b0, 3'h0));
      rdchk(t8co_pkg::ADDR_COUNTER, 32'h04);
      bus(1'b1, t8co_pkg::ADDR_FLAGS, 32'h3);
      bus(1'b1, t8co_pkg::ADDR_COUNTER, 32'h10);
      bus(1'b1, t8co_pkg::ADDR_COMPARE, 32'h05);
      bus(1'b1, t8co_pkg::ADDR_CONTROL, ctl(2'h2, 2'h0, 1'b0, 3'h1));
      wait_ev(0);
      check(n, 241);
      wait_ev(1);
      check(n, 6);
      bus(1'b1, t8co_pkg::ADDR_COMPARE, 32'h03);
      bus(1'b1, t8co_pkg::ADDR_FLAGS, 32'h3);
      bus(1'b1, t8co_pkg::ADDR_CONTROL, ctl(2'h0, 2'h2, 1'b1, 3'h0));
      bus(1'b1, t8co_pkg::ADDR_PORT, 32'h2);
      for (int i = 0; i < 7; i++) begin
         bus(1'b1, t8co_pkg::ADDR_CONTROL, ctl(2'h2, 2'h1, 1'b0, 3'h0));
         bus(1'b1, t8co_pkg::ADDR_COUNTER, 32'h0);
         bus(1'b1, t8co_pkg::ADDR_CONTROL, ctl(2'h2, 2'h1, 1'b0, 3'(i + 1)));
         wait_ev(2);
         wait_ev(2);
         check(n, DIVS[i] * 4);
      end
      check(ocf, 1);
      bus(1'b1, t8co_pkg::ADDR_CONTROL, ctl(2'h0, 2'h0, 1'b0, 3'h0));
      bus(1'b0, t8co_pkg::ADDR_COUNTER, 32'h0);
      check(rd <= 32'h03, 1);
      bus(1'b1, t8co_pkg::ADDR_COUNTER, 32'h40);
      bus(1'b1, t8co_pkg::ADDR_FLAGS, 32'h3);
      for (int j = 0; j < 4; j++) begin
         bus(1'b1, t8co_pkg::ADDR_CONTROL, ctl(2'h0, COMS[j], 1'b1, 3'h0));
         @(posedge clk);
         check(pin, j % 2 == 1);
      end
      check(ocf, 0);
      rdchk(t8co_pkg::ADDR_COUNTER, 32'h40);
      rdchk(t8co_pkg::ADDR_CONTROL, ctl(2'h0, 2'h1, 1'b0, 3'h0));
      bus(1'b1, t8co_pkg::ADDR_CONTROL, ctl(2'h2, 2'h3, 1'b0, 3'h0));
      @(posedge clk);
      check(pin, 1);
      bus(1'b1, t8co_pkg::ADDR_CONTROL, ctl(2'h1, 2'h2, 1'b1, 3'h0));
      @(posedge clk);
      check(pin, 1);
      bus(1'b1, t8co_pkg::ADDR_CONTROL, ctl(2'h0, 2'h0, 1'b1, 3'h0));
      bus(1'b1, t8co_pkg::ADDR_PORT, 32'h2);
      @(posedge clk);
      check(pin, 0);
      check(oe, 1);
      bus(1'b1, t8co_pkg::ADDR_CONTROL, ctl(2'h0, 2'h3, 1'b0, 3'h0));
      @(posedge clk);
      check(pin, 1);
      bus(1'b1, t8co_pkg::ADDR_PORT, 32'h1);
      @(posedge clk);
      check(oe, 0);
      bus(1'b1, t8co_pkg::ADDR_COMPARE, 32'h20);
      bus(1'b1, t8co_pkg::ADDR_COUNTER, 32'h20);
      bus(1'b1, t8co_pkg::ADDR_FLAGS, 32'h3);
      bus(1'b1, t8co_pkg::ADDR_CONTROL, ctl(2'h2, 2'h0, 1'b0, 3'h1));
      repeat (10) @(posedge clk);
      check(ocf, 0);
      end_of_test();
   end
endmodule : t8co_tb_top
`default_nettype wire
